/* verilog/cbt_cfg.svh */
// Register map, field positions, reset values and counts for the CAN control and bit timing block
`ifndef CBT_CFG_SVH
`define CBT_CFG_SVH

`define CBT_ADDR_W            8
`define CBT_DATA_W            32

// Register indices; byte address is four times the index
`define CBT_IDX_CONTROL0      3'h0
`define CBT_IDX_MODE_STATUS   3'h1
`define CBT_IDX_BIT_TIMING0   3'h2
`define CBT_IDX_TX_SELECT     3'h3
`define CBT_IDX_TX_VIEW       3'h4
`define CBT_IDX_IRQ_STATUS    3'h5
`define CBT_IDX_IRQ_MASK      3'h6

// Fields of bus_control_0
`define CBT_B_FRAME_RX        7
`define CBT_B_RX_ACTIVE       6
`define CBT_B_STOP_IN_WAIT    5
`define CBT_B_SYNCHRONISED    4
`define CBT_B_TIMER_ENABLE    3
`define CBT_B_WAKEUP_ENABLE   2
`define CBT_B_SLEEP_REQUEST   1
`define CBT_B_INIT_REQUEST    0

// Fields of the mode status register
`define CBT_B_INIT_ACK        0
`define CBT_B_SLEEPING        1

// Fields of bus_bit_timing_0
`define CBT_F_SJW_HI          7
`define CBT_F_SJW_LO          6
`define CBT_F_BRP_HI          5
`define CBT_F_BRP_LO          0

// Interrupt status and mask bits
`define CBT_I_FRAME_RX        0
`define CBT_I_WAKEUP          1
`define CBT_I_STAMP_DONE      2
`define CBT_IRQ_W             3

// Reset values
`define CBT_CONTROL0_RST      8'h01
`define CBT_INIT_REQUEST_RST  1'b1
`define CBT_BIT_TIMING0_RST   8'h00
`define CBT_TX_SELECT_RST     3'h0
`define CBT_IRQ_MASK_RST      3'h0

// Transmit buffers and time stamp placement
`define CBT_TX_BUFFERS        3
`define CBT_STAMP_HI_ADDR     4'he
`define CBT_STAMP_LO_ADDR     4'hf

// Time quanta in one nominal bit, minus one
`define CBT_QUANTA_LAST       4'h9

`endif

/* verilog/cbt_pkg.sv */
// Types shared by the CAN control and bit timing block
package cbt_pkg;

  // Receive front end status as seen by the control register
  typedef struct packed {
    logic frame_valid;
    logic rx_active;
    logic synchronised;
  } cbt_rx_status_type;

  // One byte write of the time stamp into the message buffer
  typedef struct packed {
    logic       write;
    logic [3:0] addr;
    logic [7:0] data;
  } cbt_stamp_wr_type;

  typedef enum logic [2:0] {
    STAMP_IDLE = 3'b001,
    STAMP_HIGH = 3'b010,
    STAMP_LOW  = 3'b100
  } cbt_stamp_state_type;

endpackage

/* verilog/cbt_divider.sv */
// Enable driven divider giving a one cycle tick every last+1 enables
`timescale 1ns/1ns
module cbt_divider #(
  parameter int WIDTH = 6
) (
  input  wire logic             clk_i,
  input  wire logic             srst_i,
  input  wire logic             clear_i,
  input  wire logic             enable_i,
  input  wire logic [WIDTH-1:0] last_i,
  output logic                  tick_o
);

  logic [WIDTH-1:0] count;

  always_ff @(posedge clk_i)
  begin
    if (srst_i || clear_i)
    begin
      count  <= '0;
      tick_o <= 1'b0;
    end
    else
    begin
      tick_o <= 1'b0;
      if (enable_i)
      begin
        if (count >= last_i)
        begin
          count  <= '0;
          tick_o <= 1'b1;
        end
        else
        begin
          count <= count + 1'b1;
        end
      end
    end
  end

endmodule // cbt_divider

/* verilog/cbt_stamp_timer.sv */
// Free running 16-bit time stamp counter clocked by the bit tick
`timescale 1ns/1ns
module cbt_stamp_timer (
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  input  wire logic        enable_i,
  input  wire logic        bit_tick_i,
  output logic      [15:0] count_o
);

  always_ff @(posedge clk_i)
  begin
    if (srst_i || !enable_i)
    begin
      count_o <= 16'h0000; // RULE_10
    end
    else if (bit_tick_i)
    begin
      count_o <= count_o + 16'h0001; // RULE_08
    end
  end

endmodule // cbt_stamp_timer

/* verilog/cbt_top.sv */
// CAN control register, bit timing register and time stamp logic behind an APB slave
//
// How it works
// RULE_01 - In initialisation mode control register reads reset, except wake, init, sleep bits.
// RULE_02 - Control register becomes writable once init request and acknowledge are both zero.
// RULE_03 - Outside init writes land; active and sync read-only; init request always writable.
// RULE_04 - Bit 7 sets on any valid received frame; write one clears; zero ignored. Frames received while LOOPBACK_I is high do not set it.
// RULE_05 - Bit 6 shows receiver front end activity; zero when transmitting or idle.
// RULE_06 - Stop-in-wait set stops interface clocks in wait mode; clear means no effect.
// RULE_07 - Bit 4 reads one only while synchronised to the bus.
// RULE_08 - Timer enable runs a 16-bit counter on the bit rate for time stamps.
// RULE_09 - After end of a valid message stamp goes to buffer bytes 0xE and 0xF.
// RULE_10 - Clearing timer enable zeroes the counter; enable is forced low during init.
// RULE_11 - Wake-up enable lets bus traffic end sleep; otherwise traffic is ignored.
// RULE_12 - Bit timing register always readable, writable only in initialisation mode.
// RULE_13 - Bits 7:6 give resync jump width of one to four quanta.
// RULE_14 - Bits 5:0 give prescaler value field plus one, one to 64.
// RULE_15 - Transmit buffer view readable only when selected buffer is empty; writes ignored.
// RULE_16 - One time quantum tick every P module clock cycles drives bit timing.
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ns
`include "cbt_cfg.svh"
module cbt_top (
  input  wire logic                           CLOCK_I,
  input  wire logic                           SRST_I,
  input  wire logic                           PSEL_I,
  input  wire logic                           PENABLE_I,
  input  wire logic                           PWRITE_I,
  input  wire logic [`CBT_ADDR_W-1:0]         PADDR_I,
  input  wire logic [`CBT_DATA_W-1:0]         PWDATA_I,
  output logic      [`CBT_DATA_W-1:0]         PRDATA_O,
  output logic                                PREADY_O,
  output logic                                PSLVERR_O,
  input  wire cbt_pkg::cbt_rx_status_type     RX_STATUS_I,
  input  wire logic                           LOOPBACK_I,
  input  wire logic                           INIT_ACK_I,
  input  wire logic                           SLEEPING_I,
  input  wire logic                           WAIT_MODE_I,
  input  wire logic                           BUS_TRAFFIC_I,
  input  wire logic                           MSG_EOF_I,
  input  wire logic [`CBT_TX_BUFFERS-1:0]     TX_EMPTY_I,
  input  wire logic [7:0]                     TX_VIEW_DATA_I,
  output logic                                INIT_REQUEST_O,
  output logic                                SLEEP_REQUEST_O,
  output logic                                STOP_CLOCKS_O,
  output logic                                WAKEUP_O,
  output logic      [`CBT_TX_BUFFERS-1:0]     TX_BUFFER_SELECT_O,
  output logic                                QUANTUM_TICK_O,
  output logic                                BIT_TICK_O,
  output logic      [2:0]                     RESYNC_JUMP_WIDTH_O,
  output cbt_pkg::cbt_stamp_wr_type           STAMP_WRITE_O,
  output logic                                IRQ_O
);

  // Software held bits of bus_control_0
  logic                        frame_received_flag;
  logic                        stop_in_wait;
  logic                        timer_enable;
  logic                        wakeup_enable;
  logic                        sleep_request;
  logic                        init_request;

  logic [7:0]                  bus_bit_timing_0;
  logic [`CBT_TX_BUFFERS-1:0]  tx_buffer_select;
  logic [`CBT_IRQ_W-1:0]       irq_status;
  logic [`CBT_IRQ_W-1:0]       irq_mask;

  logic                        init_mode;
  logic                        ctl_locked;
  logic                        setup_phase;
  logic                        wr_done;
  logic [2:0]                  reg_index;
  logic                        addr_ok;
  logic                        hit_control0;
  logic                        hit_bit_timing0;
  logic                        hit_tx_select;
  logic                        hit_irq_status;
  logic                        hit_irq_mask;
  logic [7:0]                  wr_byte;
  logic [7:0]                  control0_view;
  logic [7:0]                  next_rdata;
  logic                        next_slverr;
  logic                        tx_view_open;
  logic                        frame_event;
  logic                        wake_event;
  logic                        stamp_done;
  logic [15:0]                 stamp_count;
  logic [15:0]                 stamp_hold;
  logic [5:0]                  quantum_prescaler;
  logic [1:0]                  resync_jump_width;
  cbt_pkg::cbt_stamp_state_type stamp_state;

  assign init_mode         = init_request && INIT_ACK_I;
  // Transitional states also lock the register so no write slips in half way
  assign ctl_locked        = init_request || INIT_ACK_I; // RULE_02
  assign setup_phase       = PSEL_I && !PENABLE_I;
  assign wr_done           = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I;
  assign reg_index         = PADDR_I[4:2];
  assign addr_ok           = (PADDR_I[1:0] == 2'h0) && (PADDR_I[`CBT_ADDR_W-1:5] == '0);
  assign hit_control0      = addr_ok && (reg_index == `CBT_IDX_CONTROL0);
  assign hit_bit_timing0   = addr_ok && (reg_index == `CBT_IDX_BIT_TIMING0);
  assign hit_tx_select     = addr_ok && (reg_index == `CBT_IDX_TX_SELECT);
  assign hit_irq_status    = addr_ok && (reg_index == `CBT_IDX_IRQ_STATUS);
  assign hit_irq_mask      = addr_ok && (reg_index == `CBT_IDX_IRQ_MASK);
  assign wr_byte           = PWDATA_I[7:0];
  assign quantum_prescaler = bus_bit_timing_0[`CBT_F_BRP_HI:`CBT_F_BRP_LO];
  assign resync_jump_width = bus_bit_timing_0[`CBT_F_SJW_HI:`CBT_F_SJW_LO];
  assign tx_view_open      = |(tx_buffer_select & TX_EMPTY_I); // RULE_15
  // Loopback frames are not counted as received traffic
  assign frame_event       = RX_STATUS_I.frame_valid && !LOOPBACK_I; // RULE_04
  assign wake_event        = SLEEPING_I && wakeup_enable && BUS_TRAFFIC_I; // RULE_11

  // Control register as read, bits 7:3 held at reset values while initialising
  always_comb
  begin
    control0_view = 8'h00;
    control0_view[`CBT_B_WAKEUP_ENABLE] = wakeup_enable;
    control0_view[`CBT_B_SLEEP_REQUEST] = sleep_request;
    control0_view[`CBT_B_INIT_REQUEST]  = init_request;
    if (!init_mode)
    begin
      control0_view[`CBT_B_FRAME_RX]     = frame_received_flag;
      control0_view[`CBT_B_RX_ACTIVE]    = RX_STATUS_I.rx_active && !LOOPBACK_I; // RULE_05
      control0_view[`CBT_B_STOP_IN_WAIT] = stop_in_wait;
      control0_view[`CBT_B_SYNCHRONISED] = RX_STATUS_I.synchronised; // RULE_07
      control0_view[`CBT_B_TIMER_ENABLE] = timer_enable;
    end
  end

  // Read data and error answer, chosen in the setup cycle
  always_comb
  begin
    next_rdata  = 8'h00;
    next_slverr = 1'b0;
    if (hit_control0)
    begin
      next_rdata = control0_view;
    end
    else if (addr_ok && (reg_index == `CBT_IDX_MODE_STATUS))
    begin
      next_rdata[`CBT_B_INIT_ACK] = INIT_ACK_I;
      next_rdata[`CBT_B_SLEEPING] = SLEEPING_I;
    end
    else if (hit_bit_timing0)
    begin
      next_rdata = bus_bit_timing_0; // RULE_12
    end
    else if (hit_tx_select)
    begin
      next_rdata = {5'h00, tx_buffer_select};
    end
    else if (addr_ok && (reg_index == `CBT_IDX_TX_VIEW))
    begin
      // Closed view reads zero rather than a stale buffer
      next_rdata = tx_view_open ? TX_VIEW_DATA_I : 8'h00; // RULE_15
    end
    else if (hit_irq_status)
    begin
      next_rdata = {5'h00, irq_status};
    end
    else if (hit_irq_mask)
    begin
      next_rdata = {5'h00, irq_mask};
    end
    else
    begin
      next_slverr = 1'b1;
    end
  end

  // APB answer: no wait state, yet every bus output comes from a flop
  always_ff @(posedge CLOCK_I)
  begin
    if (SRST_I)
    begin
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O  <= '0;
    end
    else
    begin
      PREADY_O  <= setup_phase;
      PSLVERR_O <= setup_phase && next_slverr;
      if (setup_phase && !PWRITE_I)
      begin
        PRDATA_O <= {24'h000000, next_rdata};
      end
    end
  end

  // Software controlled bits of bus_control_0
  always_ff @(posedge CLOCK_I)
  begin
    if (SRST_I)
    begin
      init_request  <= `CBT_INIT_REQUEST_RST;
      sleep_request <= 1'b0;
      wakeup_enable <= 1'b0;
      stop_in_wait  <= 1'b0;
      timer_enable  <= 1'b0;
    end
    else
    begin
      if (wr_done && hit_control0)
      begin
        init_request  <= wr_byte[`CBT_B_INIT_REQUEST]; // RULE_03
        sleep_request <= wr_byte[`CBT_B_SLEEP_REQUEST];
        wakeup_enable <= wr_byte[`CBT_B_WAKEUP_ENABLE];
      end
      if (init_mode)
      begin
        stop_in_wait <= 1'b0; // RULE_01
        timer_enable <= 1'b0; // RULE_10
      end
      else if (wr_done && hit_control0 && !ctl_locked)
      begin
        stop_in_wait <= wr_byte[`CBT_B_STOP_IN_WAIT]; // RULE_03
        timer_enable <= wr_byte[`CBT_B_TIMER_ENABLE];
      end
    end
  end

  // Received frame flag: hardware set beats a software clear
  always_ff @(posedge CLOCK_I)
  begin
    if (SRST_I || init_mode)
    begin
      frame_received_flag <= 1'b0; // RULE_01
    end
    else if (frame_event)
    begin
      frame_received_flag <= 1'b1; // RULE_04
    end
    else if (wr_done && hit_control0 && !ctl_locked && wr_byte[`CBT_B_FRAME_RX])
    begin
      frame_received_flag <= 1'b0; // RULE_04
    end
  end

  // Bit timing register, only changed while initialising
  always_ff @(posedge CLOCK_I)
  begin
    if (SRST_I)
    begin
      bus_bit_timing_0 <= `CBT_BIT_TIMING0_RST;
    end
    else if (wr_done && hit_bit_timing0 && init_mode)
    begin
      bus_bit_timing_0 <= wr_byte; // RULE_12
    end
  end

  // Buffer selection and interrupt mask
  always_ff @(posedge CLOCK_I)
  begin
    if (SRST_I)
    begin
      tx_buffer_select <= `CBT_TX_SELECT_RST;
      irq_mask         <= `CBT_IRQ_MASK_RST;
    end
    else
    begin
      if (wr_done && hit_tx_select)
      begin
        tx_buffer_select <= wr_byte[`CBT_TX_BUFFERS-1:0];
      end
      if (wr_done && hit_irq_mask)
      begin
        irq_mask <= wr_byte[`CBT_IRQ_W-1:0];
      end
    end
  end

  // Sticky interrupt status, write one to clear, events win
  always_ff @(posedge CLOCK_I)
  begin
    if (SRST_I)
    begin
      irq_status <= '0;
    end
    else
    begin
      irq_status <= (irq_status
                     & ~((wr_done && hit_irq_status) ? wr_byte[`CBT_IRQ_W-1:0] : '0))
                    | {stamp_done, wake_event, frame_event};
    end
  end

  always_ff @(posedge CLOCK_I)
  begin
    if (SRST_I)
    begin
      IRQ_O <= 1'b0;
    end
    else
    begin
      IRQ_O <= |(irq_status & irq_mask);
    end
  end

  // Mode and power handshakes towards the rest of the controller
  always_ff @(posedge CLOCK_I)
  begin
    if (SRST_I)
    begin
      INIT_REQUEST_O      <= 1'b0;
      SLEEP_REQUEST_O     <= 1'b0;
      STOP_CLOCKS_O       <= 1'b0;
      WAKEUP_O            <= 1'b0;
      TX_BUFFER_SELECT_O  <= '0;
      RESYNC_JUMP_WIDTH_O <= 3'h1;
    end
    else
    begin
      INIT_REQUEST_O      <= init_request;
      SLEEP_REQUEST_O     <= sleep_request;
      // Stops the interface clocks only; the bus side keeps its own
      STOP_CLOCKS_O       <= stop_in_wait && WAIT_MODE_I; // RULE_06
      WAKEUP_O            <= wake_event; // RULE_11
      TX_BUFFER_SELECT_O  <= tx_buffer_select;
      RESYNC_JUMP_WIDTH_O <= {1'b0, resync_jump_width} + 3'h1; // RULE_13
    end
  end

  // Quantum tick every prescaler value plus one cycles
  cbt_divider #(
    .WIDTH (6)
  ) u_quantum_div (
    .clk_i    (CLOCK_I),
    .srst_i   (SRST_I),
    .clear_i  (init_mode),
    .enable_i (1'b1),
    .last_i   (quantum_prescaler), // RULE_14
    .tick_o   (QUANTUM_TICK_O)     // RULE_16
  );

  // Nominal bit built from a fixed count of quanta
  cbt_divider #(
    .WIDTH (4)
  ) u_bit_div (
    .clk_i    (CLOCK_I),
    .srst_i   (SRST_I),
    .clear_i  (init_mode),
    .enable_i (QUANTUM_TICK_O), // RULE_16
    .last_i   (`CBT_QUANTA_LAST),
    .tick_o   (BIT_TICK_O)
  );

  cbt_stamp_timer u_stamp_timer (
    .clk_i      (CLOCK_I),
    .srst_i     (SRST_I),
    .enable_i   (timer_enable), // RULE_10
    .bit_tick_i (BIT_TICK_O),   // RULE_08
    .count_o    (stamp_count)
  );

  // Time stamp store: high byte then low byte into the active buffer
  always_ff @(posedge CLOCK_I)
  begin
    if (SRST_I)
    begin
      stamp_state   <= cbt_pkg::STAMP_IDLE;
      stamp_hold    <= 16'h0000;
      stamp_done    <= 1'b0;
      STAMP_WRITE_O <= '0;
    end
    else
    begin
      stamp_done          <= 1'b0;
      STAMP_WRITE_O.write <= 1'b0;
      case (stamp_state)
        cbt_pkg::STAMP_IDLE:
        begin
          if (MSG_EOF_I && timer_enable)
          begin
            stamp_hold  <= stamp_count; // RULE_09
            stamp_state <= cbt_pkg::STAMP_HIGH;
          end
        end
        cbt_pkg::STAMP_HIGH:
        begin
          STAMP_WRITE_O.write <= 1'b1;
          STAMP_WRITE_O.addr  <= `CBT_STAMP_HI_ADDR; // RULE_09
          STAMP_WRITE_O.data  <= stamp_hold[15:8];
          stamp_state         <= cbt_pkg::STAMP_LOW;
        end
        cbt_pkg::STAMP_LOW:
        begin
          STAMP_WRITE_O.write <= 1'b1;
          STAMP_WRITE_O.addr  <= `CBT_STAMP_LO_ADDR; // RULE_09
          STAMP_WRITE_O.data  <= stamp_hold[7:0];
          stamp_done          <= 1'b1;
          stamp_state         <= cbt_pkg::STAMP_IDLE;
        end
        default:
        begin
          stamp_state <= cbt_pkg::STAMP_IDLE;
        end
      endcase
    end
  end

endmodule // cbt_top

/* testbench/cbt_checker.sv */
// Port level assertions for the control and bit timing block
`timescale 1ns/1ns
module cbt_checker (
  input wire logic                      CLOCK_I,
  input wire logic                      SRST_I,
  input wire logic                      PSEL_I,
  input wire logic                      PENABLE_I,
  input wire logic [31:0]               PRDATA_O,
  input wire logic                      PREADY_O,
  input wire logic                      PSLVERR_O,
  input wire logic                      WAIT_MODE_I,
  input wire logic                      SLEEPING_I,
  input wire logic                      BUS_TRAFFIC_I,
  input wire logic                      MSG_EOF_I,
  input wire logic                      STOP_CLOCKS_O,
  input wire logic                      WAKEUP_O,
  input wire logic [2:0]                RESYNC_JUMP_WIDTH_O,
  input wire cbt_pkg::cbt_stamp_wr_type STAMP_WRITE_O
);
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (SRST_I);
  // Completed transfer; the jump width may follow it by up to two edges
  wire logic xfer = PSEL_I & PENABLE_I & PREADY_O;
  a_ready_after_setup: assert property (PSEL_I && !PENABLE_I |=> PREADY_O)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (PREADY_O |=> !PREADY_O)
    else $error("ready longer than one cycle");
  a_error_with_ready: assert property (PSLVERR_O |-> PREADY_O && PRDATA_O[31:8] == 24'h0)
    else $error("error or upper data wrong");
  a_stop_needs_wait: assert property (!WAIT_MODE_I |=> !STOP_CLOCKS_O)
    else $error("clocks stopped outside wait");
  a_wake_cause: assert property (WAKEUP_O |-> $past(SLEEPING_I) && $past(BUS_TRAFFIC_I))
    else $error("wakeup without traffic while asleep");
  a_stamp_order: assert property (STAMP_WRITE_O.write && STAMP_WRITE_O.addr == 4'he
    |=> STAMP_WRITE_O.write && STAMP_WRITE_O.addr == 4'hf ##1 !STAMP_WRITE_O.write)
    else $error("stamp bytes out of order");
  a_stamp_cause: assert property (STAMP_WRITE_O.write && STAMP_WRITE_O.addr == 4'he
    |-> $past(MSG_EOF_I) || $past(MSG_EOF_I, 2))
    else $error("stamp without end of frame");
  a_jump_range: assert property (RESYNC_JUMP_WIDTH_O inside {[3'h1:3'h4]})
    else $error("jump width out of range");
  a_jump_held: assert property (!$past(xfer) && !$past(xfer, 2)
    |-> $stable(RESYNC_JUMP_WIDTH_O))
    else $error("jump width moved without a write");
endmodule // cbt_checker

bind cbt_top cbt_checker u_chk (.CLOCK_I, .SRST_I, .PSEL_I, .PENABLE_I, .PRDATA_O,
  .PREADY_O, .PSLVERR_O, .WAIT_MODE_I, .SLEEPING_I, .BUS_TRAFFIC_I, .MSG_EOF_I,
  .STOP_CLOCKS_O, .WAKEUP_O, .RESYNC_JUMP_WIDTH_O, .STAMP_WRITE_O);

/* testbench/cbt_bus_node.sv */
// Far side bus node seen through the receive front end
`timescale 1ns/1ns
module cbt_bus_node (
  input  wire logic                  clk_i,
  output cbt_pkg::cbt_rx_status_type rx_o,
  output logic                       traffic_o,
  output logic                       eof_o
);
  initial
  begin
    rx_o = '0;
    traffic_o = 1'b0;
    eof_o = 1'b0;
  end
  // One received frame of len cycles; sync stays up afterwards like a real bus
  task automatic frame(input int len);
    @(posedge clk_i);
    rx_o <= 3'b011;
    traffic_o <= 1'b1;
    repeat (len) @(posedge clk_i);
    rx_o <= 3'b101;
    traffic_o <= 1'b0;
    eof_o <= 1'b1;
    @(posedge clk_i);
    rx_o <= 3'b001;
    eof_o <= 1'b0;
  endtask
endmodule // cbt_bus_node

/* testbench/tb_cbt_top.sv */
// Self-checking bench for the control and bit timing block
`timescale 1ns/1ns
module tb_cbt_top;
  logic                       clk = 1'b0, srst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [7:0]                 pa = 8'h00, m = 8'h01, btr = 8'h00, txd = 8'h00;
  logic [31:0]                pd = 32'h0, prd, r;
  logic                       ack = 1'b0, slp = 1'b0, wt = 1'b0, frx = 0, act = 0, syn = 0;
  logic [2:0]                 txe = 3'h0, tsel, rjw;
  logic                       rdy, err, lerr, ireq, stc, wk, qt, irq, trf, eof, sreq, bt;
  logic                       lpb = 1'b0;
  cbt_pkg::cbt_rx_status_type rxs;
  cbt_pkg::cbt_stamp_wr_type  stw;
  logic [3:0]                 stq[$];
  int                         n_errors = 0, samples_checked = 0, seed = 5848, nwk = 0;

  always #25 clk = ~clk;
  cbt_bus_node node (.clk_i(clk), .rx_o(rxs), .traffic_o(trf), .eof_o(eof));
  cbt_top uut (.CLOCK_I(clk), .SRST_I(srst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
    .PADDR_I(pa), .PWDATA_I(pd), .PRDATA_O(prd), .PREADY_O(rdy), .PSLVERR_O(err),
    .RX_STATUS_I(rxs), .LOOPBACK_I(lpb), .INIT_ACK_I(ack), .SLEEPING_I(slp),
    .WAIT_MODE_I(wt), .BUS_TRAFFIC_I(trf), .MSG_EOF_I(eof), .TX_EMPTY_I(txe),
    .TX_VIEW_DATA_I(txd), .INIT_REQUEST_O(ireq), .SLEEP_REQUEST_O(sreq), .STOP_CLOCKS_O(stc),
    .WAKEUP_O(wk), .TX_BUFFER_SELECT_O(tsel), .QUANTUM_TICK_O(qt), .BIT_TICK_O(bt),
    .RESYNC_JUMP_WIDTH_O(rjw), .STAMP_WRITE_O(stw), .IRQ_O(irq));

  always @(posedge clk)
  begin
    if (stw.write === 1'b1) stq.push_back(stw.addr);
    if (wk === 1'b1) nwk++;
  end

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", s, e, g);
    end
  endtask

  // Master holds the request until ready is sampled; upper write bits carry noise
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1; pwr <= w; pa <= a; pd <= {$random(seed)} << 8 | d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (rdy !== 1'b1 && ++n < 20);
    r = prd;
    lerr = err;
    psel <= 1'b0; pen <= 1'b0;
    if (n == 20) chk("ready", 1, 0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic lk;
    lk = m[0] | ack;
    apb(1'b1, a, d);
    if (a == 8'h08 && m[0] && ack) btr = d;
    if (a == 8'h00 && !lk && d[7]) frx = 1'b0;
    if (a == 8'h00) m = lk ? d & 8'h07 : d & 8'h2f;
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk("read data", {24'h0, e}, r);
  endtask

  function automatic logic [7:0] ectl();
    if (m[0] & ack) return m & 8'h07;
    return (m & 8'h2f) | {frx, act, 1'b0, syn, 4'h0};
  endfunction

  task automatic init_on();
    wr(8'h00, 8'h01);
    ack <= 1'b1;
    frx = 1'b0;
    @(posedge clk);
  endtask

  task automatic frm();
    node.frame(8 + ($random(seed) & 15));
    frx = 1'b1;
    syn = 1'b1;
    repeat (4) @(posedge clk);
  endtask

  task automatic cfg(input logic [7:0] v);
    int p;
    p = 0;
    init_on();
    wr(8'h08, v);
    rc(8'h08, btr);
    wr(8'h00, 8'h00);
    ack <= 1'b0;
    do @(posedge clk); while (qt !== 1'b1 && ++p < 300);
    p = 0;
    do @(posedge clk); while (qt !== 1'b1 && ++p < 300);
    chk("quantum period", 32'(v[5:0]) + 1, p + 1);
    p = 0;
    do @(posedge clk); while (bt !== 1'b1 && ++p < 1000);
    p = 0;
    do @(posedge clk); while (bt !== 1'b1 && ++p < 1000);
    chk("bit period", 10 * (32'(v[5:0]) + 1), p + 1);
    chk("jump width", 32'(v[7:6]) + 1, rjw);
    wr(8'h08, ~v);
    rc(8'h08, v);
    $display("test bit timing %h done", v);
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    #(50 * 40000);
    n_errors++;
    results();
  end

  initial
  begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    rc(8'h00, ectl());
    ack <= 1'b1;
    @(posedge clk);
    rc(8'h00, ectl());
    apb(1'b0, 8'h1c, 8'h00);
    chk("slave error", 1, lerr);
    chk("init request", 1, ireq);
    $display("test reset done");
    for (int i = 0; i < 4; i++) cfg({2'(i), 3'h0, 3'($random(seed))});
    cfg(8'h3f);
    wr(8'h00, 8'h7e);
    rc(8'h00, ectl());
    chk("sleep request", 1, sreq);
    wt <= 1'b1;
    repeat (3) @(posedge clk);
    chk("stop clocks", 1, stc);
    wr(8'h00, 8'h0e);
    repeat (2) @(posedge clk);
    chk("stop clocks", 0, stc);
    wt <= 1'b0;
    stq.delete();
    fork
      node.frame(30);
      begin
        repeat (6) @(posedge clk);
        act = 1'b1;
        syn = 1'b1;
        rc(8'h00, ectl());
        act = 1'b0;
      end
    join
    frx = 1'b1;
    repeat (4) @(posedge clk);
    rc(8'h00, ectl());
    chk("stamp writes", 2, stq.size());
    chk("stamp high", 4'he, stq[0]);
    chk("stamp low", 4'hf, stq[1]);
    chk("masked irq", 0, irq);
    wr(8'h18, 8'h05);
    repeat (2) @(posedge clk);
    chk("irq", 1, irq);
    rc(8'h14, 8'h05);
    wr(8'h14, 8'h05);
    repeat (2) @(posedge clk);
    chk("irq", 0, irq);
    $display("test frame and stamp done");
    slp <= 1'b1;
    rc(8'h04, {6'h00, 1'b1, ack});
    nwk = 0;
    frm();
    chk("wakeup", 1, nwk != 0);
    wr(8'h00, 8'h82);
    rc(8'h00, ectl());
    nwk = 0;
    stq.delete();
    lpb <= 1'b1;
    frm();
    chk("wakeup", 0, nwk);
    chk("stamp writes", 0, stq.size());
    // Loopback frames must not raise the received frame flag
    frx = 1'b0;
    lpb <= 1'b0;
    rc(8'h00, ectl());
    slp <= 1'b0;
    $display("test wakeup done");
    wr(8'h0c, 8'h02);
    txe <= 3'b101;
    txd <= 8'($random(seed));
    rc(8'h10, 8'h00);
    chk("tx select", 3'h2, tsel);
    txe <= 3'b010;
    rc(8'h10, txd);
    $display("test tx view done");
    init_on();
    wr(8'h00, 8'h2d);
    rc(8'h00, ectl());
    wr(8'h00, 8'h00);
    ack <= 1'b0;
    @(posedge clk);
    rc(8'h00, ectl());
    $display("test init hold done");
    results();
  end
endmodule // tb_cbt_top
